// [hdl/zlak_map.svh]
// Purpose: offsets, codes and field positions for zone lock access block
// Assumes: byte addressed configuration zone
// Notes:   definitions only
`ifndef ZLAK_MAP_SVH
`define ZLAK_MAP_SVH
`define ZLAK_FIXED_LAST     7'h0c
`define ZLAK_DATA_LOCK_OFS  7'h56
`define ZLAK_CFG_LOCK_OFS   7'h57
`define ZLAK_UNLOCKED       8'h55
`define ZLAK_LOCKED         8'h00
`define ZLAK_SN0_OFS        7'h00
`define ZLAK_SN1_OFS        7'h01
`define ZLAK_SN8_OFS        7'h0c
`define ZLAK_OTP_LEGACY_HI  4'h1
`define ZLAK_ERASED_BYTE    8'hff
`endif

// [hdl/zlak_pkg.sv]
// Purpose: shared types for zone lock access block
// Assumes: none
// Notes:   none
package zlak_pkg;
  typedef enum logic [1:0] {
    ZLAK_ZONE_CFG  = 2'h0,
    ZLAK_ZONE_OTP  = 2'h1,
    ZLAK_ZONE_DATA = 2'h2
  } zlak_zone_t;
  typedef enum logic [1:0] {
    ZLAK_OTP_RO     = 2'h0,
    ZLAK_OTP_CONSUME = 2'h1,
    ZLAK_OTP_LEGACY = 2'h2
  } zlak_otp_mode_t;
  typedef enum logic [3:0] {
    ZLAK_CMD_NONCE  = 4'h1,
    ZLAK_CMD_DIGEST_GENERATE_CMD = 4'h2,
    ZLAK_CMD_MACVER = 4'h3,
    ZLAK_CMD_LOCK   = 4'h4,
    ZLAK_CMD_OTHER  = 4'h5
  } zlak_cmd_t;
  typedef enum logic [2:0] {
    ZLAK_ST_IDLE = 3'b001,
    ZLAK_ST_BUSY = 3'b010,
    ZLAK_ST_DONE = 3'b100
  } zlak_state_t;
endpackage

// [hdl/zlak_ekey.sv]
// Purpose: ephemeral key store with tag bits and valid flag
// Assumes: command outcome reported as one-cycle pulse
// Notes:   key contents leave only through the key_int output port
`timescale 1ns/1ns
module zlak_ekey
  import zlak_pkg::*;
#(
  parameter int KEY_W = 256
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             inval_evt,
  input  wire logic             cmd_end,
  input  wire zlak_cmd_t        cmd_kind,
  input  wire logic             cmd_ok,
  input  wire logic             crc_err,
  input  wire logic             mac_copy_ok,
  input  wire logic [KEY_W-1:0] new_key,
  input  wire logic [3:0]       new_slot,
  input  wire logic             new_rand,
  input  wire logic             new_verify_only,
  output logic [KEY_W-1:0]      key_int,
  output logic [3:0]            slot_selector_nibble,
  output logic                  randomness_origin_flag,
  output logic                  digest_origin_flag,
  output logic                  verify_only_taint_flag,
  output logic                  key_valid
);
  // =====================================
  // update decode
  wire is_gen   = cmd_kind == ZLAK_CMD_DIGEST_GENERATE_CMD;
  wire is_nonce = cmd_kind == ZLAK_CMD_NONCE;
  wire load_ok  = cmd_end && !crc_err && cmd_ok && (is_gen || is_nonce);
  wire keep_mac = cmd_kind == ZLAK_CMD_MACVER && cmd_ok && mac_copy_ok;
  wire clr_cmd  = cmd_end && !crc_err && !load_ok && !keep_mac;

  // =====================================
  // storage, idle keeps everything
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      key_valid <= 1'b0;
    end else if (inval_evt || clr_cmd) begin
      key_valid <= 1'b0;
    end else if (load_ok) begin
      key_valid <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      key_int                <= '0;
      slot_selector_nibble   <= 4'h0;
      randomness_origin_flag <= 1'b0;
      digest_origin_flag     <= 1'b0;
      verify_only_taint_flag <= 1'b0;
    end else if (load_ok) begin
      key_int                <= new_key;
      slot_selector_nibble   <= is_gen ? new_slot : 4'h0;
      digest_origin_flag     <= is_gen;
      randomness_origin_flag <= is_nonce ? !new_rand : 1'b0;
      verify_only_taint_flag <= is_gen && new_verify_only;
    end
  end
endmodule // zlak_ekey

// [hdl/zlak_top.sv]
// Purpose: zone lock access control and ephemeral key for auth device
// Assumes: command decoder presents one access request per cycle
// Notes:   lock bytes change only through the lock request port
`timescale 1ns/1ns
`include "zlak_map.svh"
module zlak_top
  import zlak_pkg::*;
#(
  parameter int KEY_W    = 256,
  parameter int CFG_SZ   = 88,
  parameter int OTP_SZ   = 64,
  parameter logic [7:0] REV_BYTE0 = 8'h00, // arbitrary value
  parameter logic [7:0] SN_FIX0   = 8'ha5, // arbitrary value
  parameter logic [7:0] SN_FIX1   = 8'h5a, // arbitrary value
  parameter logic [7:0] SN_FIX8   = 8'hc3  // arbitrary value
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             acc_req,
  input  wire logic             acc_write,
  input  wire zlak_zone_t       acc_zone,
  input  wire logic [6:0]       acc_addr,
  input  wire logic             acc_long,
  input  wire logic             acc_encrypted,
  input  wire logic [7:0]       acc_wdata,
  input  wire logic             lock_req,
  input  wire logic             lock_data_zone,
  input  wire zlak_otp_mode_t   otp_permission_select,
  input  wire logic             inval_evt,
  input  wire logic             cmd_end,
  input  wire zlak_cmd_t        cmd_kind,
  input  wire logic             cmd_ok,
  input  wire logic             crc_err,
  input  wire logic             mac_copy_ok,
  input  wire logic [KEY_W-1:0] new_key,
  input  wire logic [3:0]       new_slot,
  input  wire logic             new_rand,
  input  wire logic             new_verify_only,
  output logic                  acc_grant,
  output logic                  acc_error,
  output logic [7:0]            acc_rdata,
  output logic                  lock_error,
  output logic                  cfg_locked,
  output logic                  data_locked,
  output logic [23:0]           hash_fixed_serial,
  output logic [KEY_W-1:0]      key_int,
  output logic [3:0]            slot_selector_nibble,
  output logic                  randomness_origin_flag,
  output logic                  digest_origin_flag,
  output logic                  verify_only_taint_flag,
  output logic                  key_valid
);
  // =====================================
  // storage arrays
  logic [7:0] cfg_mem [CFG_SZ];
  logic [7:0] otp_mem [OTP_SZ];
  logic [7:0] config_zone_lock_byte;
  logic [7:0] data_zone_lock_byte;

  // =====================================
  // lock state decode
  assign cfg_locked  = config_zone_lock_byte != `ZLAK_UNLOCKED;
  assign data_locked = data_zone_lock_byte != `ZLAK_UNLOCKED;
  assign hash_fixed_serial = {SN_FIX0, SN_FIX1, SN_FIX8};

  // =====================================
  // access decision
  wire is_cfg  = acc_zone == ZLAK_ZONE_CFG;
  wire is_otp  = acc_zone == ZLAK_ZONE_OTP;
  wire is_data = acc_zone == ZLAK_ZONE_DATA;
  wire fixed_b = acc_addr <= `ZLAK_FIXED_LAST;
  wire lock_b  = acc_addr == `ZLAK_DATA_LOCK_OFS ||
                 acc_addr == `ZLAK_CFG_LOCK_OFS;
  wire cfg_ok  = !acc_write ||
                 (!cfg_locked && !fixed_b && !lock_b);
  wire data_ok = cfg_locked &&
                 (acc_write ? 1'b1 : data_locked);
  wire legacy_w = acc_addr[5:2] <= `ZLAK_OTP_LEGACY_HI;
  logic otp_ok;
  always_comb begin
    otp_ok = 1'b0;
    if (!cfg_locked) begin
      otp_ok = 1'b0;
    end else if (!data_locked) begin
      otp_ok = acc_write;
    end else begin
      case (otp_permission_select)
        ZLAK_OTP_RO:     otp_ok = !acc_write;
        ZLAK_OTP_LEGACY: otp_ok = !acc_write && !acc_long &&
                                  !legacy_w;
        ZLAK_OTP_CONSUME: otp_ok = 1'b0;
        default:         otp_ok = 1'b0;
      endcase
    end
  end
  wire in_range = is_cfg ? acc_addr < 7'(CFG_SZ) :
                  is_otp ? acc_addr < 7'(OTP_SZ) : 1'b1;
  wire allow = in_range &&
               ((is_cfg && cfg_ok) || (is_otp && otp_ok) ||
                (is_data && data_ok));
  wire do_cfg_wr = acc_req && allow && acc_write && is_cfg;
  wire do_otp_wr = acc_req && allow && acc_write && is_otp;
  wire [7:0] rd_byte = is_cfg ? cfg_mem[acc_addr] :
                       is_otp ? otp_mem[acc_addr[5:0]] : 8'h00;

  // =====================================
  // answer registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acc_grant <= 1'b0;
      acc_error <= 1'b0;
      acc_rdata <= 8'h00;
    end else begin
      acc_grant <= acc_req && allow;
      acc_error <= acc_req && !allow;
      acc_rdata <= (acc_req && allow && !acc_write) ? rd_byte : 8'h00;
    end
  end

  // =====================================
  // lock bytes: only lock command, one way
  wire lk_cfg  = lock_req && !lock_data_zone && !cfg_locked;
  wire lk_data = lock_req && lock_data_zone && cfg_locked && !data_locked;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      config_zone_lock_byte <= `ZLAK_UNLOCKED;
      data_zone_lock_byte   <= `ZLAK_UNLOCKED;
      lock_error            <= 1'b0;
    end else begin
      if (lk_cfg) begin
        config_zone_lock_byte <= `ZLAK_LOCKED;
      end
      if (lk_data) begin
        data_zone_lock_byte <= `ZLAK_LOCKED;
      end
      lock_error <= lock_req && !lk_cfg && !lk_data;
    end
  end

  // =====================================
  // configuration and otp contents
  genvar gi;
  generate
    for (gi = 0; gi < CFG_SZ; gi++) begin : g_cfg
      localparam logic [6:0] IDX = 7'(gi);
      if (IDX == `ZLAK_CFG_LOCK_OFS) begin : g_cl
        assign cfg_mem[gi] = config_zone_lock_byte;
      end else if (IDX == `ZLAK_DATA_LOCK_OFS) begin : g_dl
        assign cfg_mem[gi] = data_zone_lock_byte;
      end else if (IDX <= `ZLAK_FIXED_LAST) begin : g_fx
        assign cfg_mem[gi] = (IDX == `ZLAK_SN0_OFS) ? SN_FIX0 :
                             (IDX == `ZLAK_SN1_OFS) ? SN_FIX1 :
                             (IDX == `ZLAK_SN8_OFS) ? SN_FIX8 :
                             REV_BYTE0;
      end else begin : g_rw
        logic [7:0] b_q;
        always_ff @(posedge clk_sys or negedge rst_b) begin
          if (!rst_b) begin
            b_q <= 8'h00;
          end else if (do_cfg_wr && acc_addr == IDX) begin
            b_q <= acc_wdata;
          end
        end
        assign cfg_mem[gi] = b_q;
      end
    end
    for (gi = 0; gi < OTP_SZ; gi++) begin : g_otp
      logic [7:0] b_q;
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          b_q <= `ZLAK_ERASED_BYTE;
        end else if (do_otp_wr && acc_addr[5:0] == 6'(gi)) begin
          b_q <= acc_wdata;
        end
      end
      assign otp_mem[gi] = b_q;
    end
  endgenerate

  // =====================================
  // ephemeral key store
  zlak_ekey #(
    .KEY_W(KEY_W)
  ) u_ekey (
    .clk_sys               (clk_sys),
    .rst_b                 (rst_b),
    .inval_evt             (inval_evt),
    .cmd_end               (cmd_end),
    .cmd_kind              (cmd_kind),
    .cmd_ok                (cmd_ok),
    .crc_err               (crc_err),
    .mac_copy_ok           (mac_copy_ok),
    .new_key               (new_key),
    .new_slot              (new_slot),
    .new_rand              (new_rand),
    .new_verify_only       (new_verify_only),
    .key_int               (key_int),
    .slot_selector_nibble  (slot_selector_nibble),
    .randomness_origin_flag(randomness_origin_flag),
    .digest_origin_flag    (digest_origin_flag),
    .verify_only_taint_flag(verify_only_taint_flag),
    .key_valid             (key_valid)
  );
endmodule // zlak_top

// [tb/zlak_monitor.sv]
// Purpose: port checks for zone lock access block
// Assumes: one clock, async active low reset
// Notes:   bound to zlak_top
`timescale 1ns/1ns
module zlak_monitor
  import zlak_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       acc_req,
  input wire logic       acc_write,
  input wire zlak_zone_t acc_zone,
  input wire logic [6:0] acc_addr,
  input wire logic       lock_req,
  input wire logic       inval_evt,
  input wire logic       cmd_end,
  input wire zlak_cmd_t  cmd_kind,
  input wire logic       cmd_ok,
  input wire logic       crc_err,
  input wire logic       acc_grant,
  input wire logic       acc_error,
  input wire logic       cfg_locked,
  input wire logic       data_locked,
  input wire logic       digest_origin_flag,
  input wire logic       key_valid
);
  // ====================
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  one_answer_a: assert property (acc_req |=> acc_grant != acc_error)
    else $error("access not answered once");
  quiet_idle_a: assert property (!acc_req |=> !acc_grant && !acc_error)
    else $error("answer without request");
  fixed_bytes_a: assert property (acc_req && acc_write &&
    acc_zone == ZLAK_ZONE_CFG && acc_addr <= 7'h0c |=> acc_error)
    else $error("fixed byte write accepted");
  cfg_read_a: assert property (acc_req && !acc_write &&
    acc_zone == ZLAK_ZONE_CFG && acc_addr <= 7'h57 |=> acc_grant)
    else $error("config read refused");
  early_access_a: assert property (acc_req &&
    acc_zone != ZLAK_ZONE_CFG && !cfg_locked |=> acc_error)
    else $error("zone access before config lock");
  open_read_a: assert property (acc_req && !acc_write &&
    acc_zone != ZLAK_ZONE_CFG && !data_locked |=> acc_error)
    else $error("read of unlocked zone granted");
  lock_hold_a: assert property (cfg_locked |=> cfg_locked)
    else $error("config lock released");
  lock_cmd_a: assert property (!lock_req |=>
    $stable(cfg_locked) && $stable(data_locked))
    else $error("lock moved without request");
  other_clear_a: assert property (cmd_end &&
    cmd_kind == ZLAK_CMD_OTHER && !crc_err |=> !key_valid)
    else $error("valid kept after other command");
  inval_clear_a: assert property (inval_evt |=> !key_valid)
    else $error("valid kept after invalidate");
  nonce_load_a: assert property (cmd_end && cmd_kind == ZLAK_CMD_NONCE &&
    cmd_ok && !crc_err && !inval_evt |=> key_valid && !digest_origin_flag)
    else $error("nonce did not load key");
endmodule // zlak_monitor

bind zlak_top zlak_monitor zlak_monitor_inst (.clk_sys, .rst_b, .acc_req,
  .acc_write, .acc_zone, .acc_addr, .lock_req, .inval_evt, .cmd_end,
  .cmd_kind, .cmd_ok, .crc_err, .acc_grant, .acc_error, .cfg_locked,
  .data_locked, .digest_origin_flag, .key_valid);

// [tb/zlak_host.sv]
// Purpose: host side command decoder model
// Assumes: one access or lock at a time
// Notes:   idle address and data lines show inverted last value
`timescale 1ns/1ns
module zlak_host
  import zlak_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        acc_grant,
  input  wire logic        acc_error,
  input  wire logic [7:0]  acc_rdata,
  input  wire logic        lock_error,
  output logic             acc_req = 1'h0,
  output logic             acc_write = 1'h0,
  output zlak_zone_t       acc_zone = ZLAK_ZONE_CFG,
  output logic [6:0]       acc_addr = 7'h00,
  output logic             acc_long = 1'h0,
  output logic             acc_encrypted = 1'h0,
  output logic [7:0]       acc_wdata = 8'h00,
  output logic             lock_req = 1'h0,
  output logic             lock_data_zone = 1'h0
);
  // ====================
  // transfers
  task automatic access(input logic w, input zlak_zone_t z,
    input logic [6:0] a, input logic l, input logic [7:0] d,
    output logic g, output logic e, output logic [7:0] rd);
    @(posedge clk_sys);
    acc_req <= 1'h1;
    acc_write <= w;
    acc_zone <= z;
    acc_addr <= a;
    acc_long <= l;
    acc_encrypted <= w;
    acc_wdata <= d;
    @(posedge clk_sys);
    acc_req <= 1'h0;
    acc_addr <= ~a;
    acc_wdata <= ~d;
    #1;
    g = acc_grant;
    e = acc_error;
    rd = acc_rdata;
  endtask
  task automatic lock(input logic dz, output logic e);
    @(posedge clk_sys);
    lock_req <= 1'h1;
    lock_data_zone <= dz;
    @(posedge clk_sys);
    lock_req <= 1'h0;
    #1;
    e = lock_error;
  endtask
endmodule // zlak_host

// [tb/tb_top.sv]
// Purpose: self checking bench for zone lock access block
// Assumes: host model drives access and lock ports
// Notes:   serial values below are arbitrary
`timescale 1ns/1ns
module tb_top;
  import zlak_pkg::*;
  localparam logic [7:0] SN0 = 8'h3c, SN1 = 8'h4d, SN8 = 8'h5e;
  localparam zlak_zone_t C = ZLAK_ZONE_CFG, O = ZLAK_ZONE_OTP;
  localparam zlak_zone_t D = ZLAK_ZONE_DATA;
  localparam logic [255:0] KEY = {8{32'h1234abcd}};
  logic clk_sys = 1'h0, rst_b = 1'h0, inval_evt = 1'h0, cmd_end = 1'h0;
  logic cmd_ok = 1'h0, crc_err = 1'h0, mac_copy_ok = 1'h0, new_rand = 1'h0;
  logic new_verify_only = 1'h0, acc_req, acc_write, acc_long;
  logic acc_encrypted, lock_req, lock_data_zone, acc_grant, acc_error;
  logic lock_error, cfg_locked, data_locked, randomness_origin_flag;
  logic digest_origin_flag, verify_only_taint_flag, key_valid;
  logic [255:0] new_key = KEY, key_int;
  logic [3:0] new_slot = 4'h9, slot_selector_nibble;
  logic [6:0] acc_addr;
  logic [7:0] acc_wdata, acc_rdata;
  logic [23:0] hash_fixed_serial;
  zlak_zone_t acc_zone;
  zlak_cmd_t cmd_kind = ZLAK_CMD_OTHER;
  zlak_otp_mode_t otp_permission_select = ZLAK_OTP_RO;
  int errors = 0, num_checks = 0;
  logic le;
  always #10 clk_sys = ~clk_sys;
  zlak_top #(.SN_FIX0(SN0), .SN_FIX1(SN1), .SN_FIX8(SN8)) zlak_top_inst (
    .clk_sys, .rst_b, .acc_req, .acc_write, .acc_zone, .acc_addr, .acc_long,
    .acc_encrypted, .acc_wdata, .lock_req, .lock_data_zone,
    .otp_permission_select, .inval_evt, .cmd_end, .cmd_kind, .cmd_ok,
    .crc_err, .mac_copy_ok, .new_key, .new_slot, .new_rand, .new_verify_only,
    .acc_grant, .acc_error, .acc_rdata, .lock_error, .cfg_locked,
    .data_locked, .hash_fixed_serial, .key_int, .slot_selector_nibble,
    .randomness_origin_flag, .digest_origin_flag, .verify_only_taint_flag,
    .key_valid);
  zlak_host zlak_host_inst (.clk_sys, .acc_grant, .acc_error, .acc_rdata,
    .lock_error, .acc_req, .acc_write, .acc_zone, .acc_addr, .acc_long,
    .acc_encrypted, .acc_wdata, .lock_req, .lock_data_zone);
  // ====================
  // helpers
  task automatic chk(input string n, input logic [255:0] s, x);
    num_checks++;
    if (s !== x) begin
      errors++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic ac(input logic w, input zlak_zone_t z, input logic [6:0] a,
    input logic l, input logic [7:0] d, input logic eg, input logic [7:0] ed);
    logic g, e;
    logic [7:0] rd;
    zlak_host_inst.access(w, z, a, l, d, g, e, rd);
    chk("grant", g, eg);
    chk("error", e, !eg);
    if (eg && !w && z != D)
      chk("rdata", rd, ed);
  endtask
  task automatic lk(input logic dz, input logic ee);
    zlak_host_inst.lock(dz, le);
    chk("lock_error", le, ee);
  endtask
  task automatic cmd(input zlak_cmd_t k, input logic ok, crc, cp, rn, vo,
    input logic ev);
    @(posedge clk_sys);
    {cmd_end, cmd_kind, cmd_ok, crc_err} <= {1'h1, k, ok, crc};
    {mac_copy_ok, new_rand, new_verify_only} <= {cp, rn, vo};
    @(posedge clk_sys);
    cmd_end <= 1'h0;
    #1;
    chk("key_valid", key_valid, ev);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ====================
  // tests
  initial begin
    #100000;
    errors++;
    stop_test;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'h1;
    chk("serial", hash_fixed_serial, {SN0, SN1, SN8});
    ac(1'h0, C, 7'h00, 1'h0, 8'h00, 1'h1, SN0);
    ac(1'h1, C, 7'h0c, 1'h0, 8'h11, 1'h0, 8'h00);
    ac(1'h1, C, 7'h0d, 1'h0, 8'h22, 1'h1, 8'h00);
    ac(1'h0, C, 7'h0d, 1'h0, 8'h00, 1'h1, 8'h22);
    ac(1'h0, C, 7'h57, 1'h0, 8'h00, 1'h1, 8'h55);
    ac(1'h0, C, 7'h56, 1'h0, 8'h00, 1'h1, 8'h55);
    ac(1'h1, O, 7'h00, 1'h0, 8'h33, 1'h0, 8'h00);
    ac(1'h0, D, 7'h00, 1'h0, 8'h00, 1'h0, 8'h00);
    lk(1'h1, 1'h1);
    $display("test config_open done");
    lk(1'h0, 1'h0);
    chk("cfg_locked", cfg_locked, 1'h1);
    ac(1'h0, C, 7'h57, 1'h0, 8'h00, 1'h1, 8'h00);
    ac(1'h1, C, 7'h0d, 1'h0, 8'h66, 1'h0, 8'h00);
    lk(1'h0, 1'h1);
    ac(1'h1, O, 7'h00, 1'h0, 8'h33, 1'h1, 8'h00);
    ac(1'h0, O, 7'h00, 1'h0, 8'h00, 1'h0, 8'h00);
    ac(1'h0, D, 7'h04, 1'h0, 8'h00, 1'h0, 8'h00);
    ac(1'h1, D, 7'h04, 1'h0, 8'h44, 1'h1, 8'h00);
    $display("test config_locked done");
    lk(1'h1, 1'h0);
    chk("data_locked", data_locked, 1'h1);
    ac(1'h0, D, 7'h04, 1'h0, 8'h00, 1'h1, 8'h00);
    ac(1'h0, O, 7'h00, 1'h0, 8'h00, 1'h1, 8'h33);
    ac(1'h0, O, 7'h3f, 1'h1, 8'h00, 1'h1, 8'hff);
    ac(1'h1, O, 7'h05, 1'h0, 8'h00, 1'h0, 8'h00);
    ac(1'h0, O, 7'h05, 1'h0, 8'h00, 1'h1, 8'hff);
    otp_permission_select <= ZLAK_OTP_LEGACY;
    ac(1'h0, O, 7'h07, 1'h0, 8'h00, 1'h0, 8'h00);
    ac(1'h0, O, 7'h08, 1'h0, 8'h00, 1'h1, 8'hff);
    ac(1'h0, O, 7'h08, 1'h1, 8'h00, 1'h0, 8'h00);
    ac(1'h1, O, 7'h08, 1'h0, 8'h00, 1'h0, 8'h00);
    otp_permission_select <= ZLAK_OTP_CONSUME;
    ac(1'h0, O, 7'h08, 1'h0, 8'h00, 1'h0, 8'h00);
    $display("test data_locked done");
    cmd(ZLAK_CMD_NONCE, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
    chk("flags", {randomness_origin_flag, digest_origin_flag}, 2'h0);
    chk("taint", verify_only_taint_flag, 1'h0);
    cmd(ZLAK_CMD_DIGEST_GENERATE_CMD, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
    chk("flags", {randomness_origin_flag, digest_origin_flag}, 2'h1);
    chk("slot", slot_selector_nibble, 4'h9);
    chk("taint", verify_only_taint_flag, 1'h1);
    chk("key", key_int, KEY);
    cmd(ZLAK_CMD_OTHER, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1);
    cmd(ZLAK_CMD_MACVER, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1);
    cmd(ZLAK_CMD_OTHER, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    cmd(ZLAK_CMD_NONCE, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
    chk("seed_only", randomness_origin_flag, 1'h1);
    chk("gen_flag", digest_origin_flag, 1'h0);
    cmd(ZLAK_CMD_DIGEST_GENERATE_CMD, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    cmd(ZLAK_CMD_NONCE, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
    inval_evt <= 1'h1;
    @(posedge clk_sys);
    inval_evt <= 1'h0;
    #1;
    chk("key_valid", key_valid, 1'h0);
    $display("test ephemeral_key done");
    stop_test;
  end
endmodule // tb_top
